// ---- hw/cic_defs.svh ----
/*
 * offsets, field positions, reset values and timing counts of the core
 * interrupt controller. assumes inclusion by bare name from design files.
 */
`ifndef CIC_DEFS_SVH
`define CIC_DEFS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define CIC_OFS_INTCTL     8'h00
`define CIC_OFS_PCSEL      8'h04
`define CIC_OFS_PFLAGS     8'h08
`define CIC_OFS_PENABLES   8'h0c
`define CIC_OFS_EDGECFG    8'h10
`define CIC_OFS_RSTSTAT    8'h14
`define CIC_OFS_PINLEVEL   8'h18

// ****************************************************************
// interrupt_control fields
// ****************************************************************
`define CIC_B_GLOBAL_EN    7
`define CIC_B_GROUP_EN     6
`define CIC_B_WRAP_EN      5
`define CIC_B_EXTIE        4
`define CIC_B_PCIE         3
`define CIC_B_WRAP_FLAG    2
`define CIC_B_EXTIF        1
`define CIC_B_PCIF         0

// ****************************************************************
// reset values and masks
// ****************************************************************
`define CIC_RST_INTCTL     8'h00
`define CIC_RST_PCSEL      8'h00
`define CIC_RST_PERIPH     8'h00
`define CIC_PERIPH_MASK    8'hef
`define CIC_RST_EDGE       1'b1
`define CIC_PCSEL_MASK     8'h3f
`define CIC_EXT_PIN        2

// ****************************************************************
// reset_status fields
// ****************************************************************
`define CIC_B_BOR_N        0
`define CIC_B_POR_N        1
`define CIC_B_PD           3
`define CIC_B_TO           4

// ****************************************************************
// vectors and timing
// ****************************************************************
`define CIC_PC_W           13
`define CIC_VECTOR         13'h0004
`define CIC_RESET_PC       13'h0000
`define CIC_LATENCY_TICKS  3

`endif

// ---- hw/cic_pkg.sv ----
/*
 * types of the core interrupt controller.
 * assumes nothing beyond a systemverilog compiler.
 */
package cic_pkg;

	typedef enum logic [2:0]
	{
		CAUSE_POR        = 3'b000,
		CAUSE_MCLR_RUN   = 3'b001,
		CAUSE_MCLR_SLEEP = 3'b010,
		CAUSE_WDT_RESET  = 3'b011,
		CAUSE_WDT_WAKE   = 3'b100,
		CAUSE_BOR        = 3'b101
	} cic_cause_t;

	typedef enum logic [1:0]
	{
		AXI_OKAY   = 2'b00,
		AXI_SLVERR = 2'b10
	} cic_resp_t;

endpackage

// ---- hw/cic_top.sv ----
/*
 * core interrupt controller: latches edge pin, timer0 wrap, pin-change and
 * seven peripheral requests, masks them, vectors the core, handles return,
 * sleep wake-up and reset-cause status. registers over axi4-lite.
 * assumes the core gives one cycle_tick pulse per instruction cycle and
 * single-cycle pulses for returns, enable clears and reset causes.
 */
// Contract
// - global enable gates every enabled interrupt
// - any reset zeroes interrupt control
// - take: clear enable, push, load vector
// - return pops and sets global enable
// - flags set regardless of enables
// - latency three, or four for pins
// - latency independent of instruction length
// - enable clear defers due interrupt, pending
// - edge pin polarity by edge select
// - pin wake needs enable before sleep
// - analog pins read zero, no interrupts
// - timer0 wrap sets flag bit two
// - pin change flag, enable bit three, selection
// - change during port access may be lost
// - edge flag settable in any phase
// - seven peripheral flags, enables, bit4 zero
// - control register holds flags and enables
// - wake continues, vectors after next instruction
// - reset loads zero pc, cause status
// - hardware saves only return pc
// - interrupt wake with enable loads vector
`timescale 1ns/1ns
`include "cic_defs.svh"

module cic_top
#(
	parameter int PIN_COUNT   = 6,
	parameter int LATENCY_TICKS = `CIC_LATENCY_TICKS
)
(
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire logic [7:0]               s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [7:0]               s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	input  wire logic [PIN_COUNT-1:0]     gpio_pins,
	input  wire logic [PIN_COUNT-1:0]     analog_select,
	input  wire logic                     port_access,
	input  wire logic                     timer0_wrap,
	input  wire logic [7:0]               periph_events,
	input  wire logic                     cycle_tick,
	input  wire logic                     core_sleep,
	input  wire logic                     core_irq_disable,
	input  wire logic                     return_from_irq_instr,
	input  wire logic                     cause_strobe,
	input  wire cic_pkg::cic_cause_t      cause,
	output logic                          irq_request,
	output logic                          pc_load,
	output logic [`CIC_PC_W-1:0]          pc_value,
	output logic                          stack_push,
	output logic                          stack_pop,
	output logic                          wake
);

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	generate
		if (PIN_COUNT <= `CIC_EXT_PIN || PIN_COUNT > 8)
		begin : g_bad_pins
			$error("PIN_COUNT must be 3 to 8");
		end
		if (LATENCY_TICKS < 2 || LATENCY_TICKS > 15)
		begin : g_bad_lat
			$error("LATENCY_TICKS must be 2 to 15");
		end
	endgenerate

	// ****************************************************************
	// state
	// ****************************************************************
	logic [7:0]           intctl;
	logic [7:0]           pcsel;
	logic [7:0]           pflags;
	logic [7:0]           penables;
	logic                 edge_sel;
	logic [7:0]           rststat;
	logic [PIN_COUNT-1:0] pin_meta;
	logic [PIN_COUNT-1:0] pin_sync;
	logic [PIN_COUNT-1:0] pin_prev;
	logic                 sleep_prev;
	logic                 ext_wake_armed;
	logic [3:0]           lat_cnt;
	logic                 aw_held;
	logic                 w_held;
	logic [7:0]           aw_addr;
	logic [31:0]          w_data;
	logic [3:0]           w_strb;

	// ****************************************************************
	// decode, used by both read and write paths
	// ****************************************************************
	function automatic logic [2:0] reg_index(input logic [7:0] addr);
		unique case (addr)
			`CIC_OFS_INTCTL:   reg_index = 3'h1;
			`CIC_OFS_PCSEL:    reg_index = 3'h2;
			`CIC_OFS_PFLAGS:   reg_index = 3'h3;
			`CIC_OFS_PENABLES: reg_index = 3'h4;
			`CIC_OFS_EDGECFG:  reg_index = 3'h5;
			`CIC_OFS_RSTSTAT:  reg_index = 3'h6;
			`CIC_OFS_PINLEVEL: reg_index = 3'h7;
			default:           reg_index = 3'h0;
		endcase
	endfunction

	// ****************************************************************
	// pin synchronisers and event detection
	// ****************************************************************
	logic [PIN_COUNT-1:0] pin_level;
	logic [PIN_COUNT-1:0] pin_changed;
	logic                 ext_now;
	logic                 ext_was;
	logic                 ext_edge;
	logic                 pc_event;
	logic                 t0_event;
	logic [7:0]           pf_event;
	logic                 is_reset_cause;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_meta <= '0;
			pin_sync <= '0;
			pin_prev <= '0;
		end
		else
		begin
			pin_meta <= gpio_pins;
			pin_sync <= pin_meta;
			pin_prev <= pin_level;
		end
	end

	assign pin_level   = pin_sync & ~analog_select;
	assign pin_changed = (pin_level ^ pin_prev) & pcsel[PIN_COUNT-1:0] & ~analog_select;
	assign ext_now     = pin_level[`CIC_EXT_PIN];
	assign ext_was     = pin_prev[`CIC_EXT_PIN];
	// falling edge unless edge_sel; flag may set in any cycle of the instruction
	// a pin switched to analog drops to zero without making an edge
	assign ext_edge    = (edge_sel ? (ext_now & ~ext_was) : (~ext_now & ext_was))
			& ~analog_select[`CIC_EXT_PIN];
	// a change that coincides with a port access may be dropped
	assign pc_event    = (|pin_changed) & ~port_access;
	assign t0_event    = timer0_wrap;
	assign pf_event    = periph_events & `CIC_PERIPH_MASK;
	assign is_reset_cause = cause_strobe && cause != cic_pkg::CAUSE_WDT_WAKE;

	// ****************************************************************
	// request evaluation
	// ****************************************************************
	logic ctl_pending;
	logic per_pending;
	logic any_pending;
	logic take;
	logic wake_cond;

	assign ctl_pending = (intctl[`CIC_B_WRAP_FLAG] & intctl[`CIC_B_WRAP_EN])
			| (intctl[`CIC_B_EXTIF] & intctl[`CIC_B_EXTIE])
			| (intctl[`CIC_B_PCIF] & intctl[`CIC_B_PCIE]);
	assign per_pending = intctl[`CIC_B_GROUP_EN] & |(pflags & penables);
	assign any_pending = ctl_pending | per_pending;
	// latency counts instruction ticks, so instruction length cannot matter
	assign take = cycle_tick && !core_sleep && !core_irq_disable && intctl[`CIC_B_GLOBAL_EN]
			&& any_pending && lat_cnt == 4'(LATENCY_TICKS - 1);
	// edge pin wakes only if its enable was already set when sleep began
	assign wake_cond = (intctl[`CIC_B_WRAP_FLAG] & intctl[`CIC_B_WRAP_EN])
			| (intctl[`CIC_B_EXTIF] & ext_wake_armed)
			| (intctl[`CIC_B_PCIF] & intctl[`CIC_B_PCIE]) | per_pending;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			lat_cnt <= '0;
		else if (!intctl[`CIC_B_GLOBAL_EN] || !any_pending || core_irq_disable || core_sleep || take)
			lat_cnt <= '0;
		else if (cycle_tick && lat_cnt != 4'(LATENCY_TICKS - 1))
			lat_cnt <= lat_cnt + 4'h1;
	end

	// ****************************************************************
	// sleep tracking and core-facing pulses
	// ****************************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sleep_prev     <= 1'b0;
			ext_wake_armed <= 1'b0;
		end
		else
		begin
			sleep_prev <= core_sleep;
			if (core_sleep && !sleep_prev)
				ext_wake_armed <= intctl[`CIC_B_EXTIE];
			else if (!core_sleep)
				ext_wake_armed <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_request <= 1'b0;
			wake        <= 1'b0;
			stack_push  <= 1'b0;
			stack_pop   <= 1'b0;
			pc_load     <= 1'b0;
			pc_value    <= `CIC_RESET_PC;
		end
		else
		begin
			irq_request <= any_pending;
			// core resumes at the next instruction; vectoring follows via take
			wake        <= core_sleep && !wake && (wake_cond
					|| (cause_strobe && cause == cic_pkg::CAUSE_WDT_WAKE));
			// only the return address is saved by hardware
			stack_push  <= take;
			stack_pop   <= return_from_irq_instr;
			pc_load     <= take || is_reset_cause;
			if (is_reset_cause)
				pc_value <= `CIC_RESET_PC;
			else if (take)
				pc_value <= `CIC_VECTOR;
		end
	end

	// ****************************************************************
	// axi4-lite write channel
	// ****************************************************************
	logic       do_write;
	logic [2:0] w_idx;
	logic [7:0] wbyte;
	logic       next_aw_held;
	logic       next_w_held;
	logic       next_bvalid;

	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign w_idx    = reg_index(aw_addr);
	assign wbyte    = w_data[7:0];
	// readies are registered from the next holding state, so a full slot never shows ready
	assign next_aw_held = !do_write && (aw_held || (s_axi_awvalid && s_axi_awready));
	assign next_w_held  = !do_write && (w_held || (s_axi_wvalid && s_axi_wready));
	assign next_bvalid  = do_write || (s_axi_bvalid && !s_axi_bready);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= '0;
			w_data       <= '0;
			w_strb       <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= cic_pkg::AXI_OKAY;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (w_idx == 3'h0) ? cic_pkg::AXI_SLVERR : cic_pkg::AXI_OKAY;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			s_axi_awready <= !next_aw_held && !next_bvalid;
			s_axi_wready  <= !next_w_held && !next_bvalid;
		end
	end

	logic wr_lane;

	assign wr_lane = do_write && w_strb[0];

	// ****************************************************************
	// interrupt_control: hardware sets win over software clears
	// ****************************************************************
	logic [7:0] ictl_base;
	logic [7:0] ictl_set;

	always_comb
	begin
		ictl_base = (wr_lane && w_idx == 3'h1) ? wbyte : intctl;
		ictl_set  = '0;
		ictl_set[`CIC_B_WRAP_FLAG] = t0_event;
		ictl_set[`CIC_B_EXTIF] = ext_edge;
		ictl_set[`CIC_B_PCIF]  = pc_event;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || is_reset_cause)
			intctl <= `CIC_RST_INTCTL;
		else
		begin
			intctl <= ictl_base | ictl_set;
			if (take)
				intctl[`CIC_B_GLOBAL_EN] <= 1'b0;
			// the core's own enable clear defers a due request; its flag stays set
			if (core_irq_disable)
				intctl[`CIC_B_GLOBAL_EN] <= 1'b0;
			if (return_from_irq_instr)
				intctl[`CIC_B_GLOBAL_EN] <= 1'b1;
		end
	end

	// ****************************************************************
	// selection, peripheral flags and enables, edge config
	// ****************************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn || is_reset_cause)
		begin
			pcsel    <= `CIC_RST_PCSEL;
			pflags   <= `CIC_RST_PERIPH;
			penables <= `CIC_RST_PERIPH;
			edge_sel <= `CIC_RST_EDGE;
		end
		else
		begin
			if (wr_lane && w_idx == 3'h2)
				pcsel <= wbyte & `CIC_PCSEL_MASK;
			pflags <= (((wr_lane && w_idx == 3'h3) ? wbyte : pflags) | pf_event)
					& `CIC_PERIPH_MASK;
			if (wr_lane && w_idx == 3'h4)
				penables <= wbyte & `CIC_PERIPH_MASK;
			if (wr_lane && w_idx == 3'h5)
				edge_sel <= wbyte[0];
		end
	end

	// ****************************************************************
	// reset-cause status; cleared by the bus reset only, updated by causes
	// ****************************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rststat <= 8'h00;
		else if (cause_strobe)
		begin
			unique case (cause)
				cic_pkg::CAUSE_POR:
				begin
					rststat[`CIC_B_TO]    <= 1'b1;
					rststat[`CIC_B_PD]    <= 1'b1;
					rststat[`CIC_B_POR_N] <= 1'b0;
				end
				cic_pkg::CAUSE_MCLR_RUN: ;
				cic_pkg::CAUSE_MCLR_SLEEP:
				begin
					rststat[`CIC_B_TO] <= 1'b1;
					rststat[`CIC_B_PD] <= 1'b0;
				end
				cic_pkg::CAUSE_WDT_RESET:
					rststat[`CIC_B_TO] <= 1'b0;
				cic_pkg::CAUSE_WDT_WAKE:
				begin
					rststat[`CIC_B_TO] <= 1'b0;
					rststat[`CIC_B_PD] <= 1'b0;
				end
				cic_pkg::CAUSE_BOR:
				begin
					rststat[`CIC_B_TO]    <= 1'b1;
					rststat[`CIC_B_PD]    <= 1'b1;
					rststat[`CIC_B_POR_N] <= 1'b1;
					rststat[`CIC_B_BOR_N] <= 1'b0;
				end
				default: ;
			endcase
		end
		else if (wake && !s_axi_bvalid)
		begin
			// interrupt wake: timeout bit set, power-down bit clear
			if (wake_cond)
			begin
				rststat[`CIC_B_TO] <= 1'b1;
				rststat[`CIC_B_PD] <= 1'b0;
			end
		end
		else if (wr_lane && w_idx == 3'h6)
		begin
			rststat[`CIC_B_POR_N] <= wbyte[`CIC_B_POR_N];
			rststat[`CIC_B_BOR_N] <= wbyte[`CIC_B_BOR_N];
		end
	end

	// ****************************************************************
	// axi4-lite read channel
	// ****************************************************************
	logic [7:0] rd_byte;

	always_comb
	begin
		rd_byte = 8'h00;
		unique case (reg_index(s_axi_araddr))
			3'h1:    rd_byte = intctl;
			3'h2:    rd_byte = pcsel;
			3'h3:    rd_byte = pflags;
			3'h4:    rd_byte = penables;
			3'h5:    rd_byte = {7'h00, edge_sel};
			3'h6:    rd_byte = rststat;
			3'h7:    rd_byte = 8'(pin_level);
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= cic_pkg::AXI_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h000000, rd_byte};
			s_axi_rresp  <= (reg_index(s_axi_araddr) == 3'h0) ? cic_pkg::AXI_SLVERR : cic_pkg::AXI_OKAY;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// registered ready: low while an answer is outstanding or about to be
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_axi_arready <= 1'b0;
		else
			s_axi_arready <= !((s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready));
	end

endmodule

// ---- tb/cic_sva.sv ----
/*
 * port checker of the core interrupt controller.
 * assumes binding to cic_top and a single clock domain.
 */
`timescale 1ns/1ns
`include "cic_defs.svh"
module cic_sva
(
	input	wire logic	aclk,
	input	wire logic	aresetn,
	input	wire logic	cycle_tick,
	input	wire logic	core_sleep,
	input	wire logic	core_irq_disable,
	input	wire logic	return_from_irq_instr,
	input	wire logic	cause_strobe,
	input	wire cic_pkg::cic_cause_t	cause,
	input	wire logic	irq_request,
	input	wire logic	pc_load,
	input	wire logic [`CIC_PC_W-1:0]	pc_value,
	input	wire logic	stack_push,
	input	wire logic	stack_pop,
	input	wire logic	wake
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ****************************************
	// entry and return steps
	// ****************************************
	sequence s_ret;
		return_from_irq_instr ##1 stack_pop;
	endsequence
	sequence s_vec;
		stack_push && pc_load && pc_value == `CIC_VECTOR;
	endsequence

	a_take_vector: assert property (stack_push |-> s_vec)
		else $error("take without vector load");
	a_push_single: assert property (stack_push |=> !stack_push)
		else $error("take lasted two cycles");
	a_take_cause: assert property (stack_push |-> $past(cycle_tick) && $past(irq_request) && !$past(core_sleep))
		else $error("take without tick, request or while asleep");
	a_disable_block: assert property (core_irq_disable |=> !stack_push [*4])
		else $error("take after enable clear");
	a_return_pops: assert property (return_from_irq_instr |-> s_ret)
		else $error("return without pop");
	a_pop_cause: assert property (stack_pop |-> $past(return_from_irq_instr))
		else $error("pop without return");
	a_reset_pc: assert property (cause_strobe && cause != cic_pkg::CAUSE_WDT_WAKE |=> pc_load && pc_value == `CIC_RESET_PC)
		else $error("reset cause did not load zero");
	a_load_cause: assert property (pc_load |-> stack_push || $past(cause_strobe))
		else $error("stray program counter load");
	a_wake_sleep: assert property (wake |-> $past(core_sleep))
		else $error("wake while awake");
endmodule

bind cic_top cic_sva u_sva
(
	.aclk(aclk), .aresetn(aresetn), .cycle_tick(cycle_tick), .core_sleep(core_sleep),
	.core_irq_disable(core_irq_disable), .return_from_irq_instr(return_from_irq_instr),
	.cause_strobe(cause_strobe), .cause(cause), .irq_request(irq_request), .pc_load(pc_load),
	.pc_value(pc_value), .stack_push(stack_push), .stack_pop(stack_pop), .wake(wake)
);

// ---- tb/cic_core_model.sv ----
/*
 * behavioural core sequencer: makes the instruction tick, keeps the pc
 * and the return stack. assumes one clock, synchronous active-low reset.
 */
`timescale 1ns/1ns
`include "cic_defs.svh"
module cic_core_model
(
	input	wire logic	aclk,
	input	wire logic	aresetn,
	input	wire logic	pc_load,
	input	wire logic [`CIC_PC_W-1:0]	pc_value,
	input	wire logic	stack_push,
	input	wire logic	stack_pop,
	output	logic	cycle_tick,
	output	int	depth
);
	logic [1:0]	phase;
	logic [`CIC_PC_W-1:0]	pc;
	logic [`CIC_PC_W-1:0]	ret_q [$];

	// four clock phases form one instruction cycle
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			phase <= 2'h0;
			cycle_tick <= 1'b0;
			pc <= `CIC_RESET_PC;
			ret_q.delete();
		end
		else
		begin
			phase <= phase + 2'h1;
			cycle_tick <= (phase == 2'h3);
			if (stack_push)
				ret_q.push_back(pc);
			if (stack_pop && ret_q.size() > 0)
				pc <= ret_q.pop_back();
			else if (pc_load)
				pc <= pc_value;
			else if (cycle_tick)
				pc <= pc + 1'b1;
		end
		depth <= ret_q.size();
	end
endmodule

// ---- tb/tb_top.sv ----
/*
 * self-checking bench of the core interrupt controller.
 * assumes cic_top, the core model and the checker compiled before it.
 */
`timescale 1ns/1ns
`include "cic_defs.svh"
module tb_top;
	logic	aclk = 1'b0;
	logic	aresetn = 1'b0;
	logic [7:0]	awaddr = 8'h00;
	logic	awvalid = 1'b0;
	logic [31:0]	wdata = 32'h0;
	logic	wvalid = 1'b0;
	logic [7:0]	araddr = 8'h00;
	logic	arvalid = 1'b0;
	logic [5:0]	pins = 6'h00;
	logic [5:0]	ana = 6'h00;
	logic	t0w = 1'b0;
	logic [7:0]	pev = 8'h00;
	logic	slp = 1'b0;
	logic	gclr = 1'b0;
	logic	pa = 1'b0;
	logic	rfi = 1'b0;
	logic	cstb = 1'b0;
	cic_pkg::cic_cause_t	cause = cic_pkg::CAUSE_POR;
	logic	awready, wready, bvalid, arready, rvalid, tick, irq, pcl, push, pop, wake;
	logic [1:0]	bresp, rresp;
	logic [31:0]	rdata;
	logic [12:0]	pcv;
	int	depth, miscompares, num_checks, mp, me, nt, c;
	bit	hit;
	logic [7:0]	st [6] = '{8'h18, 8'h00, 8'h10, 8'h00, 8'h00, 8'h18};

	always #4 aclk = ~aclk;

	cic_top DUT
	(
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .gpio_pins(pins),
		.analog_select(ana), .port_access(pa), .timer0_wrap(t0w), .periph_events(pev),
		.cycle_tick(tick), .core_sleep(slp), .core_irq_disable(gclr), .return_from_irq_instr(rfi),
		.cause_strobe(cstb), .cause(cause), .irq_request(irq), .pc_load(pcl), .pc_value(pcv),
		.stack_push(push), .stack_pop(pop), .wake(wake)
	);

	cic_core_model u_core
	(
		.aclk(aclk), .aresetn(aresetn), .pc_load(pcl), .pc_value(pcv), .stack_push(push),
		.stack_pop(pop), .cycle_tick(tick), .depth(depth)
	);

	// ****************************************
	// compare, verdict and bus tasks
	// ****************************************
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task report_and_stop;
		if (miscompares == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task limit(input int n);
		if (n >= 100)
		begin
			miscompares++;
			$display("ERROR %0t: no answer", $time);
			report_and_stop();
		end
	endtask

	// bready and rready stay high, so the answer is taken where it is seen
	task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'b00);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while ((awvalid || wvalid || !bvalid) && n < 100);
		limit(n);
		chk(bresp, er);
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff, input logic [1:0] er = 2'b00);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (arready)
				arvalid <= 1'b0;
		end
		while ((arvalid || !rvalid) && n < 100);
		limit(n);
		chk(rdata & {24'hffffff, m}, {24'h0, e & m});
		chk(rresp, er);
	endtask

	task wtick;
		int n;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (tick !== 1'b1 && n < 100);
		limit(n);
	endtask

	// waits for a program counter load, counting instruction ticks on the way
	task wpl(input bit must);
		int n;
		n = 0;
		nt = 0;
		hit = 0;
		while (!hit && n < 100)
		begin
			@(posedge aclk);
			n++;
			nt += int'(tick === 1'b1);
			hit = (pcl === 1'b1);
		end
		if (must)
			limit(n);
	endtask

	task wrap_pulse;
		wtick();
		t0w <= 1'b1;
		@(posedge aclk);
		t0w <= 1'b0;
	endtask

	initial
	begin
		void'($urandom(93));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`CIC_OFS_INTCTL, 8'h00);
		rd(`CIC_OFS_PFLAGS, 8'h00);
		rd(`CIC_OFS_EDGECFG, 8'h01);
		rd(8'h1c, 8'h00, 8'hff, 2'b10);
		wr(8'h1c, 8'hff, 2'b10);
		wr(`CIC_OFS_PENABLES, 8'hff);
		me = 'hef;
		rd(`CIC_OFS_PENABLES, 8'(me));
		mp = $urandom & 'hff;
		pev <= 8'(mp);
		t0w <= 1'b1;
		@(posedge aclk);
		pev <= 8'h00;
		t0w <= 1'b0;
		mp &= 'hef;
		rd(`CIC_OFS_PFLAGS, 8'(mp));
		rd(`CIC_OFS_INTCTL, 8'h04);
		chk(irq, 1'b0);
		wr(`CIC_OFS_INTCTL, 8'h40);
		repeat (2) @(posedge aclk);
		chk(irq, (mp & me) != 0);
		wr(`CIC_OFS_PFLAGS, 8'h00);
		wr(`CIC_OFS_INTCTL, 8'ha0);
		wrap_pulse();
		wpl(1'b1);
		chk(nt, 3);
		chk(pcv, `CIC_VECTOR);
		rd(`CIC_OFS_INTCTL, 8'h24);
		chk(depth, 1);
		wr(`CIC_OFS_INTCTL, 8'h20);
		rfi <= 1'b1;
		@(posedge aclk);
		rfi <= 1'b0;
		@(posedge aclk);
		chk(pop, 1'b1);
		rd(`CIC_OFS_INTCTL, 8'ha0);
		chk(depth, 0);
		wrap_pulse();
		wtick();
		gclr <= 1'b1;
		@(posedge aclk);
		gclr <= 1'b0;
		wpl(1'b0);
		chk(hit, 1'b0);
		rd(`CIC_OFS_INTCTL, 8'h24);
		wr(`CIC_OFS_INTCTL, 8'ha4);
		wpl(1'b1);
		chk(pcv, `CIC_VECTOR);
		wr(`CIC_OFS_INTCTL, 8'h00);
		for (c = 1; c >= 0; c--)
		begin
			wr(`CIC_OFS_EDGECFG, 8'(c));
			pins[`CIC_EXT_PIN] <= c[0];
			repeat (6) @(posedge aclk);
			rd(`CIC_OFS_INTCTL, 8'h02);
			wr(`CIC_OFS_INTCTL, 8'h00);
		end
		pins[`CIC_EXT_PIN] <= 1'b1;
		repeat (6) @(posedge aclk);
		rd(`CIC_OFS_INTCTL, 8'h00);
		rd(`CIC_OFS_PINLEVEL, 8'h04, 8'h04);
		ana[`CIC_EXT_PIN] <= 1'b1;
		repeat (6) @(posedge aclk);
		rd(`CIC_OFS_PINLEVEL, 8'h00, 8'h04);
		pins[`CIC_EXT_PIN] <= 1'b0;
		repeat (6) @(posedge aclk);
		rd(`CIC_OFS_INTCTL, 8'h00);
		ana[`CIC_EXT_PIN] <= 1'b0;
		wr(`CIC_OFS_PCSEL, 8'hff);
		rd(`CIC_OFS_PCSEL, 8'h3f);
		wr(`CIC_OFS_PCSEL, 8'h01);
		pins[1] <= 1'b1;
		repeat (6) @(posedge aclk);
		rd(`CIC_OFS_INTCTL, 8'h00);
		pins[0] <= 1'b1;
		repeat (6) @(posedge aclk);
		rd(`CIC_OFS_INTCTL, 8'h01);
		wr(`CIC_OFS_INTCTL, 8'h00);
		pa <= 1'b1;
		pins[0] <= 1'b0;
		repeat (6) @(posedge aclk);
		pa <= 1'b0;
		rd(`CIC_OFS_INTCTL, 8'h00);
		for (c = 0; c < 6; c++)
		begin
			wr(`CIC_OFS_INTCTL, 8'h38);
			cstb <= 1'b1;
			cause <= cic_pkg::cic_cause_t'(c);
			@(posedge aclk);
			cstb <= 1'b0;
			@(posedge aclk);
			chk(pcl, c != 4);
			rd(`CIC_OFS_INTCTL, c == 4 ? 8'h38 : 8'h00);
			rd(`CIC_OFS_RSTSTAT, st[c], c == 1 ? 8'h00 : 8'h18);
		end
		wr(`CIC_OFS_INTCTL, 8'h90);
		slp <= 1'b1;
		pins[`CIC_EXT_PIN] <= 1'b1;
		nt = 0;
		while (wake !== 1'b1 && nt < 100)
		begin
			@(posedge aclk);
			nt++;
		end
		limit(nt);
		slp <= 1'b0;
		wpl(1'b1);
		chk(pcv, `CIC_VECTOR);
		rd(`CIC_OFS_RSTSTAT, 8'h10, 8'h18);
		report_and_stop();
	end
endmodule
